//--- icpd_pkg.sv
// Shared constants, types and decode helpers for the pot command decoder
package icpd_pkg;

   // Stored value width and read field width
   localparam int VAL_W  = 9;
   localparam int BYTE_W = 8;

   // Location codes of the location_select_field
   localparam logic [3:0] LOC_WIPER_ZERO = 4'h0;
   localparam logic [3:0] LOC_WIPER_ONE  = 4'h1;
   localparam logic [3:0] LOC_TERMINAL   = 4'h4;
   localparam logic [3:0] LOC_STATUS     = 4'h5;

   // Command byte field positions
   localparam int LOC_MSB = 7;
   localparam int LOC_LSB = 4;
   localparam int OP_MSB  = 3;
   localparam int OP_LSB  = 2;
   localparam int BIT_TEN = 1;
   localparam int BIT_NINE = 0;

   // Saturation limits of the two variants
   localparam logic [8:0] FULL_8BIT = 9'h100;
   localparam logic [8:0] FULL_7BIT = 9'h080;
   localparam logic [8:0] ZERO_SCALE = 9'h000;

   // Values after reset
   localparam logic [8:0] WIPER_RST_8BIT = 9'h080;
   localparam logic [8:0] WIPER_RST_7BIT = 9'h040;
   localparam logic [8:0] TERMINAL_RST   = 9'h1ff;
   localparam logic [8:0] STATUS_RST     = 9'h000;
   localparam logic [3:0] PTR_RST        = 4'h0;
   localparam logic [2:0] PIN_IDLE       = 3'h3; // Strobe low, data and clock high

   // Last bit index within a byte
   localparam logic [2:0] LAST_BIT = 3'h7;

   // Operation codes of the operation_select_field
   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_INC   = 2'b01,
      OP_DEC   = 2'b10,
      OP_READ  = 2'b11
   } icpd_op_t;

   // Bus handler states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RECV   = 3'b001,
      ST_AWAIT  = 3'b010,
      ST_ACK    = 3'b011,
      ST_SEND   = 3'b100,
      ST_MACK   = 3'b101,
      ST_MHOLD  = 3'b110,
      ST_IGNORE = 3'b111
   } icpd_state_t;

   // Meaning of the byte being received
   typedef enum logic [1:0] {
      K_CTRL = 2'b00,
      K_CMD  = 2'b01,
      K_DATA = 2'b10
   } icpd_kind_t;

   // Location and operation form a legal pair
   function automatic logic op_ok(input logic [3:0] loc, input icpd_op_t op);
      logic step_loc;
      logic rw_loc;
      step_loc = (loc == LOC_WIPER_ZERO) || (loc == LOC_WIPER_ONE);
      rw_loc   = step_loc || (loc == LOC_TERMINAL);
      unique case (op)
         OP_READ:  op_ok = rw_loc || (loc == LOC_STATUS);
         OP_WRITE: op_ok = rw_loc;
         OP_INC:   op_ok = step_loc;
         OP_DEC:   op_ok = step_loc;
      endcase
   endfunction : op_ok

endpackage : icpd_pkg

//--- icpd_pins.sv
// Pin conditioner: synchronisers, clock edges, start and stop detection
`timescale 1ns/1ps

module icpd_pins (
   input  wire logic clk_i,     // System clock
   input  wire logic rst_i,     // Async reset, active high
   input  wire logic scl_i,     // Bus clock pin
   input  wire logic sda_i,     // Bus data pin
   input  wire logic hv_i,      // High-voltage strobe pin
   output logic      scl_rise_o, // Bus clock rose
   output logic      scl_fall_o, // Bus clock fell
   output logic      sda_o,     // Synchronised data level
   output logic      hv_o,      // Synchronised strobe level
   output logic      start_o,   // Start or restart seen
   output logic      stop_o     // Stop seen
);
   import icpd_pkg::*;

   // Two sync stages plus one history stage, order {hv, sda, scl}
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] d;
   } icpd_pins_t;

   icpd_pins_t r, n;

   // Shift the pins through
   always_comb begin
      n    = r;
      n.s1 = {hv_i, sda_i, scl_i};
      n.s2 = r.s1;
      n.d  = r.s2;
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) r <= '{s1: PIN_IDLE, s2: PIN_IDLE, d: PIN_IDLE};
      else       r <= n;
   end

   // Edges and bus conditions from settled stages only
   assign scl_rise_o = r.s2[0] & ~r.d[0];
   assign scl_fall_o = ~r.s2[0] & r.d[0];
   assign sda_o      = r.s2[1];
   assign hv_o       = r.s2[2];
   assign start_o    = r.s2[0] & r.d[0] & r.d[1] & ~r.s2[1];
   assign stop_o     = r.s2[0] & r.d[0] & ~r.d[1] & r.s2[1];

endmodule : icpd_pins

//--- icpd_store.sv
// Location store: wipers, terminal control, status and registered read
`timescale 1ns/1ps

module icpd_store #(
   parameter bit RES_8BIT = 1'b1   // Variant selector
) (
   input  wire logic       clk_i,      // System clock
   input  wire logic       rst_i,      // Async reset, active high
   input  wire logic       wr_i,       // Write strobe
   input  wire logic       inc_i,      // Increment strobe
   input  wire logic       dec_i,      // Decrement strobe
   input  wire logic [3:0] loc_i,      // Target location
   input  wire logic [8:0] val_i,      // Write value
   input  wire logic [3:0] rd_loc_i,   // Read location
   output logic      [8:0] rd_data_o,  // Registered read data
   output logic      [8:0] wiper0_o,   // Wiper zero setting
   output logic      [8:0] wiper1_o,   // Wiper one setting
   output logic      [8:0] terminal_connect_control_o      // Terminal control
);
   import icpd_pkg::*;

   localparam logic [8:0] FULL  = RES_8BIT ? FULL_8BIT : FULL_7BIT;
   localparam logic [8:0] W_RST = RES_8BIT ? WIPER_RST_8BIT : WIPER_RST_7BIT;

   typedef struct packed {
      logic [8:0] w0;
      logic [8:0] w1;
      logic [8:0] tc;
      logic [8:0] rd;
   } icpd_store_t;

   icpd_store_t r, n;

   // One saturating step up or down
   function automatic logic [8:0] step(input logic [8:0] v, input logic up);
      if (up) step = (v >= FULL) ? v : 9'(v + 9'h001);
      else    step = (v == ZERO_SCALE) ? v : 9'(v - 9'h001);
   endfunction : step

   // Update and read
   always_comb begin
      n = r;
      if (wr_i) begin
         if (loc_i == LOC_WIPER_ZERO) n.w0 = val_i;
         if (loc_i == LOC_WIPER_ONE)  n.w1 = val_i;
         if (loc_i == LOC_TERMINAL)   n.tc = val_i;
      end else if (inc_i || dec_i) begin
         if (loc_i == LOC_WIPER_ZERO) n.w0 = step(r.w0, inc_i);
         if (loc_i == LOC_WIPER_ONE)  n.w1 = step(r.w1, inc_i);
      end
      unique case (rd_loc_i)
         LOC_WIPER_ZERO: n.rd = r.w0;
         LOC_WIPER_ONE:  n.rd = r.w1;
         LOC_TERMINAL:   n.rd = r.tc;
         default:        n.rd = STATUS_RST;
      endcase
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) r <= '{w0: W_RST, w1: W_RST, tc: TERMINAL_RST, rd: STATUS_RST};
      else       r <= n;
   end

   assign rd_data_o = r.rd;
   assign wiper0_o  = r.w0;
   assign wiper1_o  = r.w1;
   assign terminal_connect_control_o    = r.tc;

endmodule : icpd_store

//--- icpd_decoder.sv
// Two-wire slave command decoder for a dual volatile digital potentiometer
`timescale 1ns/1ps

// Overview of operation
// - Wipers take all four ops; terminal two
// - Command byte: location, operation, two data bits
// - Operation field selects read, write, up, down
// - Location field selects wiper, terminal, status or reserved
// - Up and down only on the wipers
// - Acknowledge legal pairs, refuse illegal ones
// - After refusal ignore all until start
// - Write value: ninth bit over data byte
// - Locations nine bits; tenth bit ignored
// - MSb per variant: ninth bit or D7
// - Read returns two bytes holding nine bits
// - Only reads and writes carry data bytes
// - Command lengths follow the byte framing
// - Start or stop mid-byte aborts the command
// - Write: control, ack, command, ack, data, ack
// - Update only after the data ack clock
// - Increment saturates at full scale
// - Read pointer: last valid command, else zero
// - Cut-off data byte is discarded
module icpd_decoder #(
   parameter bit RES_8BIT = 1'b1   // Variant: 8-bit or 7-bit network
) (
   input  wire logic                       SYS_CLK_I,        // System clock
   input  wire logic                       RESET_I,          // Async reset
   input  wire logic                       SCL_I,            // Bus clock pin
   input  wire logic                       SDA_I,            // Bus data pin in
   output logic                            SDA_O,            // Bus data drive level
   output logic                            SDA_OE_O,         // Bus data drive enable
   input  wire logic                       HIGH_VOLTAGE_STROBE_PIN_I, // Mode pin
   output logic [icpd_pkg::VAL_W-1:0]      WIPER_ZERO_O,     // Wiper zero setting
   output logic [icpd_pkg::VAL_W-1:0]      WIPER_ONE_O,      // Wiper one setting
   output logic [icpd_pkg::VAL_W-1:0]      TERMINAL_CONNECT_O, // Terminal control
   output logic                            HV_LEVEL_O,       // Strobe pin level
   output logic                            BUS_REFUSED_O     // Refused, ignoring
);
   import icpd_pkg::*;

   // Complete decoder state
   typedef struct packed {
      icpd_state_t st;       // Bus handler state
      icpd_kind_t  kind;     // Byte being received
      logic [2:0]  cnt;      // Bit index in byte
      logic [7:0]  sh;       // Receive and send shifter

      // Command fields
      logic        rw;       // Read bit of control byte
      logic [3:0]  loc;      // Latched location
      icpd_op_t    op;       // Latched operation
      logic        d8;       // Latched ninth value bit

      // Read side
      logic [3:0]  ptr;      // Read pointer
      logic        hi;       // Next read byte is the high one

      // Pin side
      logic        oe;       // Data pin pulled low
      logic        drv;      // Data drive level, always low
      logic        err;      // Refusal seen
      logic        hv;       // Strobe level copy

      // Store strobes
      logic        wr;       // Write strobe to store
      logic        inc;      // Increment strobe to store
      logic        dec;      // Decrement strobe to store
      logic [8:0]  val;      // Value for store
   } icpd_dec_t;

   // Reset value of the whole state
   localparam icpd_dec_t DEC_RST = '{
      st:   ST_IDLE,
      kind: K_CTRL,
      cnt:  3'h0,
      sh:   8'h00,
      rw:   1'b0,
      loc:  PTR_RST,
      op:   OP_WRITE,
      d8:   1'b0,
      ptr:  PTR_RST,
      hi:   1'b0,
      oe:   1'b0,
      drv:  1'b0,
      err:  1'b0,
      hv:   1'b0,
      wr:   1'b0,
      inc:  1'b0,
      dec:  1'b0,
      val:  ZERO_SCALE};

   icpd_dec_t r, n;

   // Conditioned pin events
   logic scl_rise;   // Bus clock rising
   logic scl_fall;   // Bus clock falling
   logic sda_lvl;    // Data level
   logic hv_lvl;     // Strobe level
   logic start_p;    // Start condition
   logic stop_p;     // Stop condition
   logic [8:0] rd_data;  // Value at read pointer

   // Byte to send from a stored value
   // Zeros above bit 8
   function automatic logic [7:0] read_byte(input logic [8:0] v, input logic hi);
      if (hi) read_byte = {7'h00, v[8]};
      else    read_byte = v[7:0];
   endfunction : read_byte

   // Write value from ninth bit and data byte
   // 7-bit drops the ninth bit
   function automatic logic [8:0] write_val(input logic d8, input logic [7:0] b);
      if (RES_8BIT) write_val = {d8, b};
      else          write_val = {1'b0, b};
   endfunction : write_val

   // Synchronisers and bus conditions
   // Three flip-flops per pin
   icpd_pins u_pins (
      .clk_i      (SYS_CLK_I),
      .rst_i      (RESET_I),
      .scl_i      (SCL_I),
      .sda_i      (SDA_I),
      .hv_i       (HIGH_VOLTAGE_STROBE_PIN_I),
      .scl_rise_o (scl_rise),
      .scl_fall_o (scl_fall),
      .sda_o      (sda_lvl),
      .hv_o       (hv_lvl),
      .start_o    (start_p),
      .stop_o     (stop_p)
   );

   // Location storage with saturating steps
   // Strobes land a cycle later
   icpd_store #(
      .RES_8BIT (RES_8BIT)
   ) u_store (
      .clk_i     (SYS_CLK_I),
      .rst_i     (RESET_I),
      .wr_i      (r.wr),
      .inc_i     (r.inc),
      .dec_i     (r.dec),
      .loc_i     (r.loc),
      .val_i     (r.val),
      .rd_loc_i  (r.ptr),
      .rd_data_o (rd_data),
      .wiper0_o  (WIPER_ZERO_O),
      .wiper1_o  (WIPER_ONE_O),
      .terminal_connect_control_o    (TERMINAL_CONNECT_O)
   );

   // Next-state logic
   always_comb begin
      logic [7:0] nb;   // Next byte to send
      nb    = read_byte(rd_data, r.hi);
      n     = r;

      // Strobes last one cycle
      n.wr  = 1'b0;
      n.inc = 1'b0;
      n.dec = 1'b0;

      // Strobe pin only mirrored out
      n.hv  = hv_lvl;

      // Bus conditions first
      if (start_p) begin
         // Start or restart: fresh control byte
         n.st   = ST_RECV;
         n.kind = K_CTRL;
         n.cnt  = 3'h0;
         n.oe   = 1'b0;
         n.err  = 1'b0;
      end else if (stop_p) begin
         // Stop: drop anything half received
         n.st   = ST_IDLE;
         n.oe   = 1'b0;
      end else begin
         unique case (r.st)
            // Waiting for a start
            ST_IDLE: begin
               n.oe = 1'b0;
            end

            // Refused: passive until start
            ST_IGNORE: begin
               n.oe = 1'b0;
            end

            // Shift in one byte, MSb first
            ST_RECV: begin
               if (scl_rise) begin
                  n.sh  = {r.sh[6:0], sda_lvl};
                  n.cnt = 3'(r.cnt + 3'h1);
                  if (r.cnt == LAST_BIT) begin
                     n.st = ST_AWAIT;
                  end
               end
            end

            // Byte complete: decide the answer bit
            ST_AWAIT: begin
               if (scl_fall) begin
                  unique case (r.kind)
                     K_CTRL: begin
                        n.rw = r.sh[0];
                        n.oe = 1'b1;
                        n.st = ST_ACK;
                     end
                     K_CMD: begin
                        // Split the command byte
                        n.loc = r.sh[LOC_MSB:LOC_LSB];
                        n.op  = icpd_op_t'(r.sh[OP_MSB:OP_LSB]);
                        n.d8  = r.sh[BIT_NINE];
                        if (op_ok(r.sh[LOC_MSB:LOC_LSB],
                                  icpd_op_t'(r.sh[OP_MSB:OP_LSB]))) begin
                           n.oe = 1'b1;
                           n.st = ST_ACK;
                        end else begin
                           // Leave the line high: refusal
                           n.err = 1'b1;
                           n.st  = ST_IGNORE;
                        end
                     end
                     K_DATA: begin
                        n.oe = 1'b1;
                        n.st = ST_ACK;
                     end
                     default: begin
                        n.st = ST_IGNORE;
                     end
                  endcase
               end
            end

            // Answer bit on the line; act at its end
            ST_ACK: begin
               if (scl_fall) begin
                  n.oe  = 1'b0;
                  n.cnt = 3'h0;
                  n.st  = ST_RECV;
                  n.kind = K_CMD;

                  // Act on the byte answered
                  unique case (r.kind)
                     K_CTRL: begin
                        if (r.rw) begin
                           // Read: high byte first
                           n.st = ST_SEND;
                           n.oe = ~nb[7];
                           n.sh = {nb[6:0], 1'b0};
                           n.hi = ~r.hi;
                        end
                     end
                     K_CMD: begin
                        // Any legal command moves the pointer
                        n.ptr = r.loc;
                        unique case (r.op)
                           OP_WRITE: n.kind = K_DATA;
                           OP_READ:  n.kind = K_CMD;
                           OP_INC:   n.inc  = 1'b1;
                           OP_DEC:   n.dec  = 1'b1;
                        endcase
                     end
                     K_DATA: begin
                        // Commit only now the ack clock is done
                        n.val = write_val(r.d8, r.sh);
                        n.wr  = 1'b1;
                     end
                     default: begin
                        n.st = ST_IGNORE;
                     end
                  endcase
               end
            end

            // Shift out one byte, line driven low for zeros
            ST_SEND: begin
               if (scl_fall) begin
                  if (r.cnt == LAST_BIT) begin
                     n.oe = 1'b0;    // Free line for master answer
                     n.st = ST_MACK;
                  end else begin
                     n.cnt = 3'(r.cnt + 3'h1);
                     n.oe  = ~r.sh[7];
                     n.sh  = {r.sh[6:0], 1'b0};
                  end
               end
            end

            // Sample master answer
            ST_MACK: begin
               if (scl_rise) begin
                  if (sda_lvl) begin
                     // Master declined: read is over
                     n.st = ST_IDLE;
                  end else begin
                     n.st = ST_MHOLD;
                  end
               end
            end

            // Master wants more: next byte on the fall
            ST_MHOLD: begin
               if (scl_fall) begin
                  n.st  = ST_SEND;
                  n.cnt = 3'h0;
                  n.oe  = ~nb[7];
                  n.sh  = {nb[6:0], 1'b0};
                  n.hi  = ~r.hi;
               end
            end
         endcase
      end

      // Each read sequence opens with the high byte
      if (start_p) begin
         n.hi = 1'b1;
      end
   end

   // State register
   // Reset loads constants only
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         r <= DEC_RST;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from flip-flops
   // Open drain: enable decides
   assign SDA_O         = r.drv;
   assign SDA_OE_O      = r.oe;
   assign HV_LEVEL_O    = r.hv;
   assign BUS_REFUSED_O = r.err;

endmodule : icpd_decoder

//--- icpd_decoder_asserts.sv
// Port checker for the pot command decoder
`timescale 1ns/1ps
module icpd_decoder_asserts
   import icpd_pkg::*;
(
   input wire logic             SYS_CLK_I,
   input wire logic             RESET_I,
   input wire logic             SCL_I,
   input wire logic             SDA_I,
   input wire logic             SDA_O,
   input wire logic             SDA_OE_O,
   input wire logic             HIGH_VOLTAGE_STROBE_PIN_I,
   input wire logic [VAL_W-1:0] WIPER_ZERO_O,
   input wire logic [VAL_W-1:0] WIPER_ONE_O,
   input wire logic [VAL_W-1:0] TERMINAL_CONNECT_O,
   input wire logic             HV_LEVEL_O,
   input wire logic             BUS_REFUSED_O
);
   logic       scl_p;   // Previous clock pin
   logic       sda_p;   // Previous data line
   logic [3:0] since_s; // Clocks since a start on the pins
   logic [1:0] since_r; // Clocks since reset release
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RESET_I);
   // Start detector and age counters
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
         since_s <= 4'hf;
         since_r <= 2'h0;
      end else begin
         scl_p <= SCL_I;
         sda_p <= SDA_I;
         if (scl_p && SCL_I && sda_p && !SDA_I) begin
            since_s <= 4'h0;
         end else if (since_s != 4'hf) begin
            since_s <= since_s + 4'h1;
         end
         if (since_r != 2'h3) begin
            since_r <= since_r + 2'h1;
         end
      end
   end
   chk_sda_low_only: assert property (!SDA_O)
      else $error("data drive level not low");
   chk_oe_scl_low: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I, 2))
      else $error("data drive changed with clock high");
   chk_refuse_quiet: assert property (BUS_REFUSED_O |-> !SDA_OE_O)
      else $error("data driven while refusing");
   chk_refuse_frozen: assert property (BUS_REFUSED_O && $past(BUS_REFUSED_O)
      |-> $stable({WIPER_ZERO_O, WIPER_ONE_O, TERMINAL_CONNECT_O}))
      else $error("location changed while refusing");
   chk_refuse_clear: assert property ($fell(BUS_REFUSED_O) |-> since_s < 4'h9)
      else $error("refusal cleared without start");
   chk_update_ack: assert property ($changed({WIPER_ZERO_O, WIPER_ONE_O,
      TERMINAL_CONNECT_O}) |-> !SDA_OE_O && ($past(SDA_OE_O, 1)
      || $past(SDA_OE_O, 2) || $past(SDA_OE_O, 3)))
      else $error("location changed away from acknowledge end");
   chk_hv_follow: assert property (since_r == 2'h3
      |-> HV_LEVEL_O == $past(HIGH_VOLTAGE_STROBE_PIN_I, 3))
      else $error("strobe level copy wrong");
   chk_reset_quiet: assert property ($fell(RESET_I) |-> !SDA_OE_O [*3])
      else $error("data driven after reset");
   cov_refused: cover property ($rose(BUS_REFUSED_O));
   cov_wiper_one: cover property ($changed(WIPER_ONE_O));
   cov_ack_hv: cover property ($rose(SDA_OE_O) && HV_LEVEL_O);
endmodule : icpd_decoder_asserts

bind icpd_decoder icpd_decoder_asserts u_chk (
   .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
   .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
   .HIGH_VOLTAGE_STROBE_PIN_I(HIGH_VOLTAGE_STROBE_PIN_I),
   .WIPER_ZERO_O(WIPER_ZERO_O), .WIPER_ONE_O(WIPER_ONE_O),
   .TERMINAL_CONNECT_O(TERMINAL_CONNECT_O), .HV_LEVEL_O(HV_LEVEL_O),
   .BUS_REFUSED_O(BUS_REFUSED_O)
);

//--- icpd_i2c_master.sv
// Two-wire bus master model, 80 ns bit clock
`timescale 1ns/1ps
module icpd_i2c_master (
   input  wire logic clk_i, // System clock
   input  wire logic sda_i, // Wired data line
   output logic      scl_o, // Bus clock, idles high
   output logic      sda_o  // Data drive, 1 releases
);
   // Idle bus
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Wait n system clocks
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask : hold
   // Start or restart, leaves clock low
   task automatic start();
      sda_o <= 1'b1;
      hold(2);
      scl_o <= 1'b1;
      hold(4);
      sda_o <= 1'b0;
      hold(4);
      scl_o <= 1'b0;
      hold(2);
   endtask : start
   // Stop, leaves bus idle
   task automatic stop();
      sda_o <= 1'b0;
      hold(2);
      scl_o <= 1'b1;
      hold(4);
      sda_o <= 1'b1;
      hold(4);
   endtask : stop
   // One bit clock, line sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_o <= b;
      hold(2);
      scl_o <= 1'b1;
      hold(4);
      r = sda_i;
      scl_o <= 1'b0;
      hold(2);
   endtask : bit_io
   // Byte out MSB first, then the device acknowledge
   task automatic send(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : send
   // Byte in, then master ack (0) or not-ack (1)
   task automatic recv(input logic nack, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         v[i] = r;
      end
      bit_io(nack, r);
   endtask : recv
endmodule : icpd_i2c_master

//--- icpd_decoder_tb_top.sv
// Self-checking bench for the pot command decoder
`timescale 1ns/1ps
module icpd_decoder_tb_top;
   import icpd_pkg::*;
   logic        sys_clk = 1'b0; // System clock
   logic        rst     = 1'b1; // Reset
   logic        hv_pin  = 1'b0; // Strobe pin
   logic        scl;            // Bus clock
   logic        m_sda;          // Master data drive
   logic        oe;             // Device pulls data low
   logic [8:0]  w0, w1, tc, w0_7; // Location outputs
   logic        hv_lvl;         // Strobe copy
   logic        refused;        // Refusal flag
   logic [15:0] rv;             // Read result
   logic        ack;            // Last acknowledge
   int          mismatches  = 0;
   int          checks_done = 0;
   int          cycles      = 0;
   wire         sda_line = m_sda & ~oe; // Pulled-up open drain
   always #5 sys_clk = ~sys_clk;
   icpd_i2c_master m (.clk_i(sys_clk), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));
   icpd_decoder dut (
      .SYS_CLK_I(sys_clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda_line), .SDA_O(),
      .SDA_OE_O(oe), .HIGH_VOLTAGE_STROBE_PIN_I(hv_pin), .WIPER_ZERO_O(w0),
      .WIPER_ONE_O(w1), .TERMINAL_CONNECT_O(tc), .HV_LEVEL_O(hv_lvl),
      .BUS_REFUSED_O(refused));
   icpd_decoder #(.RES_8BIT(1'b0)) dut7 (
      .SYS_CLK_I(sys_clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda_line), .SDA_O(),
      .SDA_OE_O(), .HIGH_VOLTAGE_STROBE_PIN_I(hv_pin), .WIPER_ZERO_O(w0_7),
      .WIPER_ONE_O(), .TERMINAL_CONNECT_O(), .HV_LEVEL_O(), .BUS_REFUSED_O());
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Start, write control byte, command byte
   task automatic cmd(input logic [3:0] loc, input icpd_op_t op, input logic [1:0] d);
      logic a;
      m.start();
      m.send(8'h5c, a);
      m.send({loc, op, d}, ack);
   endtask : cmd
   // Single write
   task automatic wr(input logic [3:0] loc, input logic [1:0] d, input logic [7:0] b);
      logic a;
      cmd(loc, OP_WRITE, d);
      m.send(b, a);
      m.stop();
      check({15'h0, a}, 16'h1);
   endtask : wr
   // Two-byte read at the pointer
   task automatic rd();
      logic a;
      m.start();
      m.send(8'h5d, a);
      m.recv(1'b0, rv[15:8]);
      m.recv(1'b1, rv[7:0]);
      m.stop();
   endtask : rd
   // Reset values, default pointer
   task automatic t_reset();
      check({7'h00, tc}, {7'h00, TERMINAL_RST});
      check({7'h00, w0_7}, {7'h00, WIPER_RST_7BIT});
      rd();
      check(rv, {7'h00, WIPER_RST_8BIT});
   endtask : t_reset
   // Full scale write, saturating steps
   task automatic t_steps();
      wr(LOC_WIPER_ZERO, 2'b11, 8'h00);
      check({7'h00, w0}, 16'h0100);
      check({7'h00, w0_7}, 16'h0000);
      wr(LOC_WIPER_ZERO, 2'b00, 8'hff);
      cmd(LOC_WIPER_ZERO, OP_INC, 2'b00);
      m.send({LOC_WIPER_ZERO, OP_INC, 2'b00}, ack);
      m.stop();
      check({15'h0, ack}, 16'h1);
      check({7'h00, w0}, {7'h00, FULL_8BIT});
      wr(LOC_WIPER_ONE, 2'b00, 8'h01);
      cmd(LOC_WIPER_ONE, OP_DEC, 2'b00);
      m.send({LOC_WIPER_ONE, OP_DEC, 2'b00}, ack);
      m.stop();
      check({7'h00, w1}, 16'h0000);
      cmd(LOC_WIPER_ONE, OP_INC, 2'b00);
      m.stop();
      check({7'h00, w1}, 16'h0001);
   endtask : t_steps
   // Terminal and status reads
   task automatic t_reads();
      wr(LOC_TERMINAL, 2'b00, 8'ha5);
      check({7'h00, tc}, 16'h00a5);
      cmd(LOC_TERMINAL, OP_READ, 2'b00);
      rd();
      check(rv, 16'h00a5);
      cmd(LOC_STATUS, OP_READ, 2'b00);
      rd();
      check(rv, {7'h00, STATUS_RST});
   endtask : t_reads
   // Stop inside a data byte
   task automatic t_abort();
      logic r;
      cmd(LOC_WIPER_ZERO, OP_WRITE, 2'b00);
      for (int i = 0; i < 4; i++) m.bit_io(1'b0, r);
      m.stop();
      check({7'h00, w0}, {7'h00, FULL_8BIT});
   endtask : t_abort
   // Illegal pairs lock the bus until a start
   task automatic t_refuse();
      logic [5:0] bad [6];
      bad = '{6'h11, 6'h12, 6'h0a, 6'h14, 6'h3f, 6'h15};
      foreach (bad[i]) begin
         cmd(bad[i][5:2], icpd_op_t'(bad[i][1:0]), 2'b01);
         check({15'h0, ack}, 16'h0);
         check({15'h0, refused}, 16'h1);
         m.send({LOC_WIPER_ONE, OP_WRITE, 2'b01}, ack);
         m.send(8'h77, ack);
         m.stop();
         check({7'h00, w1}, 16'h0001);
         m.start();
         check({15'h0, refused}, 16'h0);
         m.stop();
      end
   endtask : t_refuse
   // Elevated strobe level changes nothing
   task automatic t_hv();
      hv_pin <= 1'b1;
      wr(LOC_WIPER_ONE, 2'b01, 8'hc3);
      check({15'h0, hv_lvl}, 16'h1);
      cmd(LOC_WIPER_ONE, OP_INC, 2'b00);
      m.stop();
      cmd(LOC_WIPER_ONE, OP_READ, 2'b00);
      rd();
      check(rv, 16'h01c3);
      hv_pin <= 1'b0;
   endtask : t_hv
   // Verdict and end of run
   task automatic final_report();
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   // Hang guard
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         mismatches++;
         final_report();
      end
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      t_reset();
      t_steps();
      t_reads();
      t_abort();
      t_refuse();
      t_hv();
      final_report();
   end
endmodule : icpd_decoder_tb_top
